// ===== design/rsc_pkg.sv
// Purpose: Shared constants and types of the reset source control block
// Assumes: Register indices sit at byte address four times the index
// Notes: Narrow registers occupy the low byte of each 32-bit word
package rsc_pkg;

    // Avalon byte address width needed to reach the highest index
    localparam int ADDR_W = 14;
    localparam int IDX_W = 12;

    // Register indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_CAUSE = 12'hfcc;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'hfd0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'hfd1;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 12'hfde;
    localparam logic [IDX_W-1:0] IDX_KEY = 12'hfdf;

    // Key codes
    localparam logic [7:0] KEY_EXT_DIS = 8'hb2;
    localparam logic [7:0] KEY_FLAG_CLR = 8'h71;

    // Configuration and status field positions
    localparam int CFG_EXT_DIS = 0;
    localparam int CFG_AREA = 1;
    localparam int CFG_VECT = 2;

    // Cause register field positions
    localparam int CAUSE_WDT = 0;
    localparam int CAUSE_SYSCLK = 1;
    localparam int CAUSE_VD1 = 2;
    localparam int CAUSE_VD2 = 3;
    localparam int CAUSE_TRIM = 4;
    localparam int CAUSE_TRIM_DS = 5;
    localparam int CAUSE_FLASH = 6;
    localparam int CAUSE_FCLR = 7;

    // Reset values and masks
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] CAUSE_SRC_MASK = 8'h5f;

    // Internal reset sources, one level each
    typedef struct packed {
        logic flash_standby;
        logic trim;
        logic volt_det2;
        logic volt_det1;
        logic sysclk_fault;
        logic watchdog;
    } rsc_src_t;

    // Places the internal sources into the cause register layout
    function automatic logic [7:0] cause_bits(input rsc_src_t s);
        logic [7:0] b;
        b = 8'h00;
        b[CAUSE_WDT] = s.watchdog;
        b[CAUSE_SYSCLK] = s.sysclk_fault;
        b[CAUSE_VD1] = s.volt_det1;
        b[CAUSE_VD2] = s.volt_det2;
        b[CAUSE_TRIM] = s.trim;
        b[CAUSE_FLASH] = s.flash_standby;
        return b;
    endfunction

endpackage

// ===== design/rsc_reset_source_control.sv
// Purpose: Reset source combiner with keyed configuration and cause flags
// Assumes: rst_i is the power-on reset; all inputs synchronous to mclk_i
// Notes: Avalon-MM slave, one wait cycle on every access
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Contract
// [RULE1] System reset is the OR of external, power-on and six internal sources.
// [RULE2] Committed config bit 0 at 1 disables the external reset input.
// [RULE3] Written disable bit acts only after key 0xB2 commits it.
// [RULE4] Committed disable returns to default only on power-on reset.
// [RULE5] Written, uncommitted config clears on any reset.
// [RULE6] Config bits 7 to 3 read zero.
// [RULE7] Config bits 2 and 1 commit by own key, mirrored in status.
// [RULE8] Key register is write-only; 0xB2, 0x71 act, others ignored. The code also acts on KEY_AREA (0xA5 by default).
// [RULE9] Software writes the key as a whole byte, no read-modify-write.
// [RULE10] Software writes keys only in normal mode, gear select 00.
// [RULE11] Status at key address shows committed disable in bit 0.
// [RULE12] Each internal source sets its sticky cause flag.
// [RULE13] Cause bit 5 reads 1 once abnormal trimming data is seen.
// [RULE14] Cause flags clear only by power-on, external reset or keyed clear.
// [RULE15] Clear bit 7 then key 0x71 clears all flags and the bit.
// [RULE16] Cause bit 7 always reads zero.
// [RULE17] Any reset holds warm-up counter, CPU and peripherals in reset.
// [RULE18] Voltage detectors disabled only by external or power-on reset.
// [RULE19] Cause flags are not cleared by the reset they record.
module rsc_reset_source_control #(
    parameter int ADDR_W = rsc_pkg::ADDR_W,
    // Arbitrary code committing bits 2 and 1; no value is defined for it
    parameter logic [7:0] KEY_AREA = 8'ha5
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic ext_reset_i,
    input wire rsc_pkg::rsc_src_t src_i,
    input wire logic trim_abnormal_i,
    output logic sys_reset_o,
    output logic volt_det_disable_o,
    output logic ext_reset_disable_o,
    output logic reset_area_ctrl_o,
    output logic reset_vector_ctrl_o,
    output logic irq_o
);

    // Refuse address widths that cannot reach the highest index
    if (ADDR_W < rsc_pkg::IDX_W + 2) begin : g_addr_check
        $error("rsc: ADDR_W too narrow for the register map");
    end

    // Bus decode
    logic [rsc_pkg::IDX_W-1:0] idx;
    logic aligned;
    logic req;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;

    assign idx = avs_address_i[rsc_pkg::IDX_W+1:2];
    assign aligned = (avs_address_i[1:0] == 2'b00);
    assign req = avs_read_i | avs_write_i;
    // Access completes at the edge where waitrequest is low
    assign acc = req & ~avs_waitrequest_o;
    assign wr_acc = acc & avs_write_i & aligned & avs_byteenable_i[0];
    assign rd_acc = acc & avs_read_i & aligned;
    assign wbyte = avs_writedata_i[7:0];

    // Register state
    logic [2:0] cfg_pend_reg, cfg_pend_next;
    logic [2:0] cfg_comm_reg, cfg_comm_next;
    logic fclr_pend_reg, fclr_pend_next;
    logic [7:0] cause_reg, cause_next;
    logic [7:0] irq_stat_reg, irq_stat_next;
    logic [7:0] irq_mask_reg, irq_mask_next;
    logic sys_rst_reg, sys_rst_next;
    logic vd_dis_reg, vd_dis_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;

    // Reset source terms
    logic ext_rst_eff;
    logic int_rst;
    logic any_rst;
    logic key_wr;
    logic key_ext;
    logic key_clr;
    logic key_area;
    logic flag_clr;
    logic [7:0] src_bits;

    // External input is gated by the committed disable, not the pending one
    assign ext_rst_eff = ext_reset_i & ~cfg_comm_reg[rsc_pkg::CFG_EXT_DIS]; // [RULE2]
    assign int_rst = |src_i;
    assign any_rst = ext_rst_eff | int_rst; // [RULE1]
    assign src_bits = rsc_pkg::cause_bits(src_i);

    // Key decode: whole byte compared, other codes fall through
    assign key_wr = wr_acc & (idx == rsc_pkg::IDX_KEY);
    assign key_ext = key_wr & (wbyte == rsc_pkg::KEY_EXT_DIS); // [RULE8]
    assign key_clr = key_wr & (wbyte == rsc_pkg::KEY_FLAG_CLR); // [RULE8]
    assign key_area = key_wr & (wbyte == KEY_AREA);
    assign flag_clr = ext_rst_eff | (key_clr & fclr_pend_reg); // [RULE14]

    // Read data mux; unmapped or misaligned words read zero
    function automatic logic [7:0] read_byte(
        input logic [rsc_pkg::IDX_W-1:0] i,
        input logic [2:0] pend,
        input logic [2:0] comm,
        input logic [7:0] cause,
        input logic [7:0] stat,
        input logic [7:0] mask
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            rsc_pkg::IDX_CONFIG: v[2:0] = pend; // [RULE6]
            rsc_pkg::IDX_KEY: v[2:0] = comm; // [RULE11] [RULE7]
            rsc_pkg::IDX_CAUSE: v = cause & ~8'h80; // [RULE16]
            rsc_pkg::IDX_IRQ_STAT: v = stat;
            rsc_pkg::IDX_IRQ_MASK: v = mask;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Bus handshake: one wait cycle, data sampled while waiting
    always_comb begin
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        if (req && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = 32'h0000_0000;
            if (aligned && avs_read_i) begin
                rdata_next[7:0] = read_byte(idx, cfg_pend_reg,
                    cfg_comm_reg, cause_reg, irq_stat_reg, irq_mask_reg);
            end
        end
    end

    // Configuration: pending contents, commit by key, clear on reset
    always_comb begin
        cfg_pend_next = cfg_pend_reg;
        cfg_comm_next = cfg_comm_reg;
        if (any_rst) begin
            cfg_pend_next = rsc_pkg::CFG_RESET; // [RULE5]
        end else if (wr_acc && idx == rsc_pkg::IDX_CONFIG) begin
            cfg_pend_next = wbyte[2:0]; // [RULE7]
        end
        // Commit survives external and internal resets
        if (key_ext && !any_rst) begin
            cfg_comm_next[rsc_pkg::CFG_EXT_DIS] =
                cfg_pend_reg[rsc_pkg::CFG_EXT_DIS]; // [RULE3] [RULE4]
        end
        if (key_area && !any_rst) begin
            cfg_comm_next[rsc_pkg::CFG_VECT:rsc_pkg::CFG_AREA] =
                cfg_pend_reg[rsc_pkg::CFG_VECT:rsc_pkg::CFG_AREA]; // [RULE7]
        end
    end

    // Cause flags: set wins over any clear in the same cycle
    always_comb begin
        fclr_pend_next = fclr_pend_reg;
        cause_next = flag_clr ? rsc_pkg::CAUSE_RESET : cause_reg; // [RULE15]
        cause_next = cause_next | src_bits; // [RULE12] [RULE19]
        if (trim_abnormal_i) begin
            cause_next[rsc_pkg::CAUSE_TRIM_DS] = 1'b1; // [RULE13]
        end
        if (any_rst || key_clr) begin
            fclr_pend_next = 1'b0; // [RULE15]
        end else if (wr_acc && idx == rsc_pkg::IDX_CAUSE) begin
            fclr_pend_next = wbyte[rsc_pkg::CAUSE_FCLR];
        end
    end

    // Interrupt status: a read clears only the bits it actually returned,
    // so an event landing during the wait cycle is not lost
    always_comb begin
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (rd_acc && idx == rsc_pkg::IDX_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~rdata_reg[7:0];
        end
        irq_stat_next = irq_stat_next | src_bits;
        if (wr_acc && idx == rsc_pkg::IDX_IRQ_MASK) begin
            irq_mask_next = wbyte & rsc_pkg::CAUSE_SRC_MASK;
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // Reset outputs follow the sources one cycle later
    always_comb begin
        sys_rst_next = any_rst; // [RULE17]
        vd_dis_next = ext_rst_eff; // [RULE18]
    end

    // Power-on reset initialises everything, including committed values
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg_pend_reg <= rsc_pkg::CFG_RESET;
            cfg_comm_reg <= rsc_pkg::CFG_RESET; // [RULE4]
            fclr_pend_reg <= 1'b0;
            cause_reg <= rsc_pkg::CAUSE_RESET; // [RULE14]
            irq_stat_reg <= rsc_pkg::IRQ_RESET;
            irq_mask_reg <= rsc_pkg::IRQ_RESET;
            sys_rst_reg <= 1'b1; // [RULE17]
            vd_dis_reg <= 1'b1; // [RULE18]
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            cfg_pend_reg <= cfg_pend_next;
            cfg_comm_reg <= cfg_comm_next;
            fclr_pend_reg <= fclr_pend_next;
            cause_reg <= cause_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            sys_rst_reg <= sys_rst_next;
            vd_dis_reg <= vd_dis_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign sys_reset_o = sys_rst_reg;
    assign volt_det_disable_o = vd_dis_reg;
    assign ext_reset_disable_o = cfg_comm_reg[rsc_pkg::CFG_EXT_DIS];
    assign reset_area_ctrl_o = cfg_comm_reg[rsc_pkg::CFG_AREA];
    assign reset_vector_ctrl_o = cfg_comm_reg[rsc_pkg::CFG_VECT];
    assign irq_o = irq_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    property p_sys_reset;
        any_rst |=> sys_reset_o;
    endproperty
    a_sys_reset: assert property (p_sys_reset) // [RULE1] [RULE17]
        else $error("system reset missed an active source");

    property p_ext_disabled;
        ext_reset_disable_o && !int_rst |=> !sys_reset_o;
    endproperty
    a_ext_disabled: assert property (p_ext_disabled) // [RULE2]
        else $error("disabled external input still caused reset");

    property p_commit;
        !key_ext |=> $stable(ext_reset_disable_o);
    endproperty
    a_commit: assert property (p_commit) // [RULE3]
        else $error("disable changed without its key");

    property p_keep_commit;
        any_rst |=> $stable(cfg_comm_reg);
    endproperty
    a_keep_commit: assert property (p_keep_commit) // [RULE4]
        else $error("committed setting changed by non power-on reset");

    property p_pend_clear;
        any_rst |=> cfg_pend_reg == 3'h0;
    endproperty
    a_pend_clear: assert property (p_pend_clear) // [RULE5]
        else $error("pending config not cleared by reset");

    property p_cfg_read;
        rd_acc && idx == rsc_pkg::IDX_CONFIG |-> avs_readdata_o[31:3] == '0;
    endproperty
    a_cfg_read: assert property (p_cfg_read) // [RULE6]
        else $error("config upper bits read nonzero");

    property p_status_read;
        rd_acc && idx == rsc_pkg::IDX_KEY
            |-> avs_readdata_o[2:0] == $past(cfg_comm_reg);
    endproperty
    a_status_read: assert property (p_status_read) // [RULE11] [RULE7]
        else $error("status does not mirror committed bits");

    // A clearing event in the middle cycle may legally drop the flag
    property p_flag_set;
        src_i.watchdog ##1 (!src_i.watchdog && !flag_clr)
            ##1 !src_i.watchdog |-> cause_reg[rsc_pkg::CAUSE_WDT];
    endproperty
    a_flag_set: assert property (p_flag_set) // [RULE12] [RULE19]
        else $error("watchdog cause flag lost after the reset");

    property p_flag_hold;
        !flag_clr |=> (cause_reg & $past(cause_reg)) == $past(cause_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold) // [RULE14]
        else $error("cause flag cleared without a clearing event");

    property p_keyed_clear;
        key_clr && fclr_pend_reg && src_bits == 8'h00 && !trim_abnormal_i
            |=> cause_reg == 8'h00 && !fclr_pend_reg;
    endproperty
    a_keyed_clear: assert property (p_keyed_clear) // [RULE15]
        else $error("keyed clear did not clear the flags");

    property p_cause_read;
        rd_acc && idx == rsc_pkg::IDX_CAUSE |-> !avs_readdata_o[7];
    endproperty
    a_cause_read: assert property (p_cause_read) // [RULE16]
        else $error("clear request bit read as one");

    property p_vd_dis;
        int_rst && !ext_rst_eff |=> !volt_det_disable_o;
    endproperty
    a_vd_dis: assert property (p_vd_dis) // [RULE18]
        else $error("internal reset disabled voltage detectors");

    c_commit: cover property (key_ext ##1 ext_reset_disable_o);
    c_clear: cover property (key_clr && fclr_pend_reg ##1 cause_reg == 8'h00);
    c_irq: cover property (src_i.watchdog ##[1:3] irq_o);

endmodule

// ===== tb/rsc_src_model.sv
// Purpose: Far-side model of the reset pin and on-chip reset sources
// Assumes: Bench pulses evt_i for one cycle to start an event
// Notes: Events are levels held for HOLD cycles, then released to 0
`timescale 1ns/1ps
module rsc_src_model #(
    parameter int HOLD = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] evt_i,
    output rsc_pkg::rsc_src_t src_o,
    output logic ext_reset_o,
    output logic trim_abnormal_o
);
    logic [7:0] pat_reg;
    logic [7:0] pat_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // A new event replaces the old one; sources drop together at the end
    always_comb begin
        pat_next = pat_reg;
        cnt_next = cnt_reg;
        if (evt_i != 8'h00) begin
            pat_next = evt_i;
            cnt_next = HOLD[3:0];
        end else if (cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1;
        end
    end

    // Registered so sources never change in the design's sampling step
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pat_reg <= 8'h00;
            cnt_reg <= 4'h0;
        end else begin
            pat_reg <= pat_next;
            cnt_reg <= cnt_next;
        end
    end

    // Bit 6 is the pin, bit 7 the trim status, bits 5:0 the struct
    assign {trim_abnormal_o, ext_reset_o, src_o} =
        (cnt_reg != 4'h0) ? pat_reg : 8'h00;
endmodule

// ===== tb/rsc_reset_source_control_tb.sv
// Purpose: Self-checking bench for the reset source controller
// Assumes: One wait cycle per access, but the bus waits for waitrequest
// Notes: Key writes are whole bytes, never read-modify-write
`timescale 1ns/1ps
module rsc_reset_source_control_tb;
    localparam logic [7:0] KA = 8'ha5;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [rsc_pkg::ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [3:0] be = 4'h1;
    logic [31:0] rdat;
    logic wreq;
    logic [7:0] evt = 8'h00;
    rsc_pkg::rsc_src_t src;
    logic ext, trim, sysr, vdd, dis, area, vect, irq;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;

    rsc_reset_source_control #(.KEY_AREA(KA)) u_rsc_reset_source_control (
        .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .ext_reset_i(ext), .src_i(src),
        .trim_abnormal_i(trim), .sys_reset_o(sysr),
        .volt_det_disable_o(vdd), .ext_reset_disable_o(dis),
        .reset_area_ctrl_o(area), .reset_vector_ctrl_o(vect), .irq_o(irq));

    rsc_src_model #(.HOLD(4)) u_rsc_src_model (
        .mclk_i(mclk_i), .rst_i(rst_i), .evt_i(evt), .src_o(src),
        .ext_reset_o(ext), .trim_abnormal_o(trim));

    // 250 MHz system clock
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            $display("Error at %0t: run timed out", $time);
            test_done();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [11:0] idx,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        adr <= {idx, 2'b00};
        wr <= w;
        rd <= ~w;
        wdat <= {24'h000000, d};
        do begin
            @(posedge mclk_i);
            n = n + 1;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat[7:0];
        if (n >= 20) begin
            cmp1(wreq, 1'b0);
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic chk_reg(input logic [11:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        cmp8(q, exp);
    endtask

    // Raise an event, check reset outputs mid-event and system reset after it ends
    task automatic fire(input logic [7:0] e, input logic r, input logic v);
        @(posedge mclk_i);
        evt <= e;
        @(posedge mclk_i);
        evt <= 8'h00;
        repeat (2) @(posedge mclk_i);
        #1;
        cmp1(sysr, r);
        cmp1(vdd, v);
        repeat (6) @(posedge mclk_i);
        #1;
        cmp1(sysr, 1'b0);
    endtask

    // Reset outputs drop at the first edge after release; look once settled
    task automatic t_reset_vals;
        #1;
        cmp1(sysr, 1'b0);
        cmp1(vdd, 1'b0);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h00);
        chk_reg(rsc_pkg::IDX_CONFIG, 8'h00);
        chk_reg(rsc_pkg::IDX_KEY, 8'h00);
        chk_reg(12'h001, 8'h00);
        $display("test reset values done");
    endtask

    task automatic t_keys;
        wr_reg(rsc_pkg::IDX_CONFIG, 8'hff);
        chk_reg(rsc_pkg::IDX_CONFIG, 8'h07);
        chk_reg(rsc_pkg::IDX_KEY, 8'h00);
        wr_reg(rsc_pkg::IDX_KEY, 8'h55);
        chk_reg(rsc_pkg::IDX_KEY, 8'h00);
        wr_reg(rsc_pkg::IDX_KEY, rsc_pkg::KEY_EXT_DIS);
        chk_reg(rsc_pkg::IDX_KEY, 8'h01);
        cmp1(dis, 1'b1);
        wr_reg(rsc_pkg::IDX_KEY, KA);
        chk_reg(rsc_pkg::IDX_KEY, 8'h07);
        cmp1(area & vect, 1'b1);
        fire(8'h40, 1'b0, 1'b0);
        $display("test keys done");
    endtask

    task automatic t_internal;
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < 6; i++) begin
            fire(8'h01 << i, 1'b1, 1'b0);
            e = e | ((i < 5) ? (8'h01 << i) : 8'h40);
            chk_reg(rsc_pkg::IDX_CAUSE, e);
        end
        chk_reg(rsc_pkg::IDX_CONFIG, 8'h00);
        chk_reg(rsc_pkg::IDX_KEY, 8'h07);
        fire(8'h80, 1'b0, 1'b0);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h7f);
        $display("test internal sources done");
    endtask

    task automatic t_flags;
        wr_reg(rsc_pkg::IDX_KEY, rsc_pkg::KEY_FLAG_CLR);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h7f);
        wr_reg(rsc_pkg::IDX_CAUSE, 8'h80);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h7f);
        wr_reg(rsc_pkg::IDX_KEY, rsc_pkg::KEY_FLAG_CLR);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h00);
        fire(8'h01, 1'b1, 1'b0);
        wr_reg(rsc_pkg::IDX_KEY, rsc_pkg::KEY_FLAG_CLR);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h01);
        $display("test flag clear done");
    endtask

    // Status bits are read-to-clear; only the watchdog bit is unmasked
    task automatic t_irq;
        logic [7:0] q;
        bus(1'b0, rsc_pkg::IDX_IRQ_STAT, 8'h00, q);
        wr_reg(rsc_pkg::IDX_IRQ_MASK, 8'h01);
        chk_reg(rsc_pkg::IDX_IRQ_MASK, 8'h01);
        fire(8'h02, 1'b1, 1'b0);
        cmp1(irq, 1'b0);
        chk_reg(rsc_pkg::IDX_IRQ_STAT, 8'h02);
        fire(8'h01, 1'b1, 1'b0);
        cmp1(irq, 1'b1);
        chk_reg(rsc_pkg::IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge mclk_i);
        #1;
        cmp1(irq, 1'b0);
        $display("test interrupt done");
    endtask

    task automatic t_ext_por;
        wr_reg(rsc_pkg::IDX_CONFIG, 8'h00);
        wr_reg(rsc_pkg::IDX_KEY, rsc_pkg::KEY_EXT_DIS);
        chk_reg(rsc_pkg::IDX_KEY, 8'h06);
        wr_reg(rsc_pkg::IDX_CONFIG, 8'h01);
        fire(8'h40, 1'b1, 1'b1);
        chk_reg(rsc_pkg::IDX_CAUSE, 8'h00);
        chk_reg(rsc_pkg::IDX_CONFIG, 8'h00);
        chk_reg(rsc_pkg::IDX_KEY, 8'h06);
        // Mid-run power-on reset; outputs were launched one edge earlier
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        cmp1(sysr & vdd, 1'b1);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        cmp1(sysr | vdd, 1'b0);
        chk_reg(rsc_pkg::IDX_KEY, 8'h00);
        cmp1(area | vect | dis, 1'b0);
        $display("test external and power-on reset done");
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Power-on reset for 12 cycles, then the scenarios in order
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset_vals();
        t_keys();
        t_internal();
        t_flags();
        t_irq();
        t_ext_por();
        test_done();
    end
endmodule
